// File: core/rpc_consts.vh
`ifndef RPC_CONSTS_VH
`define RPC_CONSTS_VH

// register byte addresses
`define RPC_ADDR_CTRL 8'h00
`define RPC_ADDR_STATUS 8'h04
`define RPC_ADDR_CAUSE 8'h08
`define RPC_ADDR_PROT 8'h0C

// control register fields
`define RPC_CTRL_DPD_LOCK 0
`define RPC_CTRL_BOD_INT_SEL 1
`define RPC_CTRL_BOD_RST_SEL 2
`define RPC_CTRL_BOD_RST_EN 3
`define RPC_CTRL_ISP_SAMPLE_DIS 4
`define RPC_CTRL_CLK_ALT 5
`define RPC_CTRL_BOOT_MAP 6
`define RPC_CTRL_DPD_REQ 8
`define RPC_CTRL_RESET 7'h40

// status register fields
`define RPC_STAT_BOD_INT 0
`define RPC_STAT_BOD_RST 1
`define RPC_STAT_JTAG 2
`define RPC_STAT_SWD 3
`define RPC_STAT_LVL_LO 4
`define RPC_STAT_LVL_HI 5

// reset cause fields
`define RPC_CAUSE_PIN 0
`define RPC_CAUSE_WDT 1
`define RPC_CAUSE_POR 2
`define RPC_CAUSE_BOD 3
`define RPC_CAUSE_WAKE 4
`define RPC_CAUSE_REFUSED 5
`define RPC_CAUSE_RESET 6'h04

// synchroniser lanes and their idle levels
`define RPC_SYNC_W 6
`define RPC_SYNC_RST_PIN 0
`define RPC_SYNC_WAKE_PIN 1
`define RPC_SYNC_RTC 2
`define RPC_SYNC_WDT 3
`define RPC_SYNC_BOD0 4
`define RPC_SYNC_BOD1 5
`define RPC_SYNC_IDLE 6'h03

// timing
`define RPC_CLK_PERIOD_PS 5000
`define RPC_RST_PULSE_NS 50
`define RPC_RST_PULSE_CYC ((`RPC_RST_PULSE_NS * 1000) / `RPC_CLK_PERIOD_PS)
`define RPC_RST_FILT_CYC (`RPC_RST_PULSE_CYC / 2)
`define RPC_RST_HOLD_CYC 8
`define RPC_BSCAN_WAIT_US 250

`endif

// File: core/rpc_sync.v
`timescale 1ns/1ps
// two-flop synchroniser, one lane per bit; stage one feeds stage two only
module rpc_sync #(
  parameter W = 1,
  parameter [W-1:0] IDLE = {W{1'b0}}
) (
  input wire CLOCK,
  input wire RST_N,
  input wire [W-1:0] D,
  output reg [W-1:0] Q
);
  reg [W-1:0] meta;

  // idle levels keep sources quiet while reset releases
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      meta <= IDLE;
      Q <= IDLE;
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule // rpc_sync

// File: core/rpc_top.v
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "rpc_consts.vh"
module rpc_top #(
  parameter RST_HOLD = `RPC_RST_HOLD_CYC,
  parameter FILT = `RPC_RST_FILT_CYC,
  parameter [31:0] PROT1_PATTERN = 32'h0000_0001,
  parameter [31:0] PROT2_PATTERN = 32'h0000_0002,
  parameter [31:0] PROT3_PATTERN = 32'h0000_0003
) (
  input wire CLOCK,
  input wire RST_N,
  input wire RESET_PIN_N,
  input wire WAKE_REQUEST_PIN_N,
  input wire RTC_WAKE,
  input wire WDT_RESET,
  input wire BOD_BELOW_L0,
  input wire BOD_BELOW_L1,
  input wire [31:0] PROT_WORD,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg CHIP_RESET_N,
  output reg IRC_ENABLE,
  output reg FLASH_INIT,
  output reg MAIN_POWER_EN,
  output reg DPD_ACTIVE,
  output wire CLK_SEL_ALT,
  output wire BOOT_MAP,
  output reg BOD_IRQ,
  output reg SWD_ENABLE,
  output reg JTAG_BSCAN_ENABLE,
  output reg ISP_ENABLE,
  output reg ISP_SECTOR0_LOCK,
  output reg ISP_ERASE_ONLY,
  output reg ISP_PIN_SAMPLE,
  output reg IAP_ENABLE
);
  localparam [2:0] ST_RESET = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_DPD = 3'h4;

  // protection levels as decoded from the flash word
  localparam [1:0] LVL_OPEN = 2'h0;
  localparam [1:0] LVL_ONE = 2'h1;
  localparam [1:0] LVL_TWO = 2'h2;
  localparam [1:0] LVL_THREE = 2'h3;

  wire [`RPC_SYNC_W-1:0] s;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] hold_cnt;
  reg [7:0] next_hold_cnt;
  reg [3:0] pin_cnt;
  reg pin_rst;
  reg [6:0] ctrl;
  reg [6:0] next_ctrl;
  reg [5:0] cause;
  reg [5:0] next_cause;
  reg [1:0] prot_lvl;
  reg [1:0] word_lvl;
  reg dpd_req;

  wire in_dpd = state[2];
  wire pin_hi = s[`RPC_SYNC_RST_PIN];
  wire bod_int = ctrl[`RPC_CTRL_BOD_INT_SEL] ?
    s[`RPC_SYNC_BOD1] : s[`RPC_SYNC_BOD0];
  wire bod_lvl = ctrl[`RPC_CTRL_BOD_RST_SEL] ?
    s[`RPC_SYNC_BOD1] : s[`RPC_SYNC_BOD0];

  // reset pin, wake pin and the async source lines are all resynchronised
  rpc_sync #(
    .W(`RPC_SYNC_W),
    .IDLE(`RPC_SYNC_IDLE)
  ) u_sync (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .D({BOD_BELOW_L1, BOD_BELOW_L0, WDT_RESET, RTC_WAKE,
        WAKE_REQUEST_PIN_N, RESET_PIN_N}),
    .Q(s)
  );

  // reset sources; pin, watchdog and brownout are dead in deep power-down
  // (their logic is unpowered there, so a floating input must not count)
  wire src_pin = pin_rst & ~in_dpd;
  wire src_wdt = s[`RPC_SYNC_WDT] & ~in_dpd;
  wire src_bod = ctrl[`RPC_CTRL_BOD_RST_EN] & bod_lvl & ~in_dpd;
  wire any_src = src_pin | src_wdt | src_bod;
  // wake is a low level on the wake pin or the rtc wake line
  wire wake = ~s[`RPC_SYNC_WAKE_PIN] | s[`RPC_SYNC_RTC];

  // bus handshake: answer in the second access cycle
  wire apb_acc = PSEL & PENABLE & ~PREADY;
  wire apb_done = PSEL & PENABLE & PREADY;
  // one select per register word; the two low address bits are ignored
  wire sel_ctrl = (PADDR[7:2] == `RPC_ADDR_CTRL >> 2);
  wire sel_status = (PADDR[7:2] == `RPC_ADDR_STATUS >> 2);
  wire sel_cause = (PADDR[7:2] == `RPC_ADDR_CAUSE >> 2);
  wire sel_prot = (PADDR[7:2] == `RPC_ADDR_PROT >> 2);
  // writes land only at the completing edge, never during setup
  wire wr_ctrl = apb_done & PWRITE & sel_ctrl;
  wire wr_cause = apb_done & PWRITE & sel_cause;
  wire mapped = sel_ctrl | sel_status | sel_cause | sel_prot;

  // pin filter: a few consecutive low samples, well under the shortest pulse
  // a glitch shorter than the filter never reaches the reset tree; filter
  // plus the two sync flops still fits inside the shortest legal pulse
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_cnt <= 4'h0;
      pin_rst <= 1'b0;
    end else if (pin_hi) begin
      pin_cnt <= 4'h0;
      pin_rst <= 1'b0;
    end else begin
      if (pin_cnt != FILT[3:0])
        pin_cnt <= pin_cnt + 4'h1;
      pin_rst <= (pin_cnt >= FILT[3:0] - 4'h1);
    end
  end

  // power and reset sequencing
  // wake does not count as a source: once in reset it may stay asserted
  // without stretching the hold time
  always @* begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    case (state)
      ST_RESET: begin
        // hold until every source has been quiet for the hold time
        if (any_src) begin
          next_hold_cnt = 8'h00;
        end else if (hold_cnt == RST_HOLD[7:0] - 8'h01) begin
          next_state = ST_RUN;
          next_hold_cnt = 8'h00;
        end else begin
          next_hold_cnt = hold_cnt + 8'h01;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          next_state = ST_RESET;
        end else if (dpd_req && !ctrl[`RPC_CTRL_DPD_LOCK]) begin
          next_state = ST_DPD;
        end
      end
      ST_DPD: begin
        // only wake sources leave; a wake is a full chip reset
        if (wake) begin
          next_state = ST_RESET;
          next_hold_cnt = 8'h00;
        end
      end
      default: begin
        next_state = ST_RESET;
        next_hold_cnt = 8'h00;
      end
    endcase
  end

  // state and hold counter; power-on always starts from reset
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_RESET;
      hold_cnt <= 8'h00;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // control register; chip reset reloads defaults, clock back to rc
  always @* begin
    next_ctrl = ctrl;
    if (state[0]) begin
      next_ctrl = `RPC_CTRL_RESET;
    end else if (wr_ctrl) begin
      next_ctrl = PWDATA[6:0];
    end
  end

  // cause flags: a set in the clearing cycle wins
  // so software clearing old causes cannot lose a fresh event
  always @* begin
    next_cause = cause;
    if (wr_cause)
      next_cause = cause & ~PWDATA[5:0];
    if (state[1] && src_pin)
      next_cause[`RPC_CAUSE_PIN] = 1'b1;
    if (state[1] && src_wdt)
      next_cause[`RPC_CAUSE_WDT] = 1'b1;
    if (state[1] && src_bod)
      next_cause[`RPC_CAUSE_BOD] = 1'b1;
    if (in_dpd && wake)
      next_cause[`RPC_CAUSE_WAKE] = 1'b1;
    if (state[1] && dpd_req && ctrl[`RPC_CTRL_DPD_LOCK])
      next_cause[`RPC_CAUSE_REFUSED] = 1'b1;
  end

  // protection level decoded from the flash word
  // any word that is not a pattern leaves the part open
  always @* begin
    if (PROT_WORD == PROT3_PATTERN)
      word_lvl = LVL_THREE;
    else if (PROT_WORD == PROT2_PATTERN)
      word_lvl = LVL_TWO;
    else if (PROT_WORD == PROT1_PATTERN)
      word_lvl = LVL_ONE;
    else
      word_lvl = LVL_OPEN;
  end

  // registers; the protection word is taken only while in reset
  // level resets to the strictest so nothing opens before the word is seen
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= `RPC_CTRL_RESET;
      cause <= `RPC_CAUSE_RESET;
      prot_lvl <= 2'h3;
      dpd_req <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      cause <= next_cause;
      dpd_req <= wr_ctrl & PWDATA[`RPC_CTRL_DPD_REQ] & state[1];
      if (state[0])
        prot_lvl <= word_lvl;
    end
  end

  assign CLK_SEL_ALT = ctrl[`RPC_CTRL_CLK_ALT];
  assign BOOT_MAP = ctrl[`RPC_CTRL_BOOT_MAP];

  // bus slave; unmapped addresses answer with an error and zero data
  // one wait state keeps read data registered, at the cost of a cycle
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= apb_acc;
      PSLVERR <= apb_acc & ~mapped;
      PRDATA <= 32'h0000_0000;
      if (apb_acc && !PWRITE) begin
        case (PADDR[7:2])
          `RPC_ADDR_CTRL >> 2: PRDATA <= {25'h0, ctrl};
          `RPC_ADDR_STATUS >> 2: begin
            PRDATA[`RPC_STAT_BOD_INT] <= bod_int;
            PRDATA[`RPC_STAT_BOD_RST] <= bod_lvl;
            PRDATA[`RPC_STAT_JTAG] <= JTAG_BSCAN_ENABLE;
            PRDATA[`RPC_STAT_SWD] <= SWD_ENABLE;
            PRDATA[`RPC_STAT_LVL_HI:`RPC_STAT_LVL_LO] <= prot_lvl;
          end
          `RPC_ADDR_CAUSE >> 2: PRDATA <= {26'h0, cause};
          `RPC_ADDR_PROT >> 2: PRDATA <= {30'h0, prot_lvl};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // power, clock and reset outputs follow the next state
  // driving from next state keeps all of them aligned with the state flop
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CHIP_RESET_N <= 1'b0;
      IRC_ENABLE <= 1'b1;
      FLASH_INIT <= 1'b1;
      MAIN_POWER_EN <= 1'b1;
      DPD_ACTIVE <= 1'b0;
      BOD_IRQ <= 1'b0;
    end else begin
      CHIP_RESET_N <= ~next_state[0];
      IRC_ENABLE <= ~next_state[2];
      FLASH_INIT <= next_state[0];
      // only the wake logic and rtc domain stay powered
      MAIN_POWER_EN <= ~next_state[2];
      DPD_ACTIVE <= next_state[2];
      BOD_IRQ <= bod_int & ~next_state[2];
    end
  end

  // debug and programming gates; safe (locked) until protection is known
  // in-application programming stays on at every level by design
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SWD_ENABLE <= 1'b0;
      JTAG_BSCAN_ENABLE <= 1'b0;
      ISP_ENABLE <= 1'b0;
      ISP_SECTOR0_LOCK <= 1'b0;
      ISP_ERASE_ONLY <= 1'b0;
      ISP_PIN_SAMPLE <= 1'b0;
      IAP_ENABLE <= 1'b1;
    end else begin
      // swd needs pin high, out of reset and no protection
      SWD_ENABLE <= pin_hi & next_state[1] &
        (prot_lvl == 2'h0);
      // scan path only; it has no route into the processor
      JTAG_BSCAN_ENABLE <= ~pin_hi & ~next_state[2];
      ISP_ENABLE <= (prot_lvl != 2'h3);
      ISP_SECTOR0_LOCK <= (prot_lvl == 2'h1);
      ISP_ERASE_ONLY <= (prot_lvl == 2'h2);
      ISP_PIN_SAMPLE <= (prot_lvl != 2'h3) &
        ~ctrl[`RPC_CTRL_ISP_SAMPLE_DIS];
      IAP_ENABLE <= 1'b1;
    end
  end
endmodule // rpc_top

// File: verification/rpc_far_side.sv
`timescale 1ns/1ps
// far side: reset and wake pins, supply monitor, watchdog, flash word
module rpc_far_side (
  input wire clk,
  input wire dpd,
  output wire reset_pin_n,
  output logic wake_pin_n,
  output logic rtc_wake,
  output logic wdt_reset,
  output logic below_l0,
  output logic below_l1,
  output logic [31:0] prot_word
);
  logic pin_lvl;
  // the pull-up owns the pin while the part sleeps, never left floating
  assign reset_pin_n = dpd ? 1'b1 : pin_lvl;
  // wake pin idles high; only a low level asks for wake-up
  initial begin
    {pin_lvl, wake_pin_n, rtc_wake} = 3'b110;
    {wdt_reset, below_l0, below_l1} = 3'b000;
    prot_word = 32'h0;
  end
  // {pin, wake, rtc, watchdog, lvl0, lvl1}, changed just after an edge
  task set_lines(input logic [5:0] v);
    @(posedge clk);
    {pin_lvl, wake_pin_n, rtc_wake, wdt_reset, below_l0, below_l1} <= v;
  endtask
  // flash word is only read while chip reset is held
  task set_prot(input logic [31:0] w);
    @(posedge clk);
    prot_word <= w;
  endtask
endmodule // rpc_far_side

// File: verification/rpc_top_sva.sv
`timescale 1ns/1ps
// watches the top module pins only
module rpc_top_chk #(
  parameter FILT = 5
) (
  input wire CLOCK,
  input wire RST_N,
  input wire RESET_PIN_N,
  input wire WAKE_REQUEST_PIN_N,
  input wire RTC_WAKE,
  input wire PREADY,
  input wire PSLVERR,
  input wire CHIP_RESET_N,
  input wire IRC_ENABLE,
  input wire FLASH_INIT,
  input wire MAIN_POWER_EN,
  input wire DPD_ACTIVE,
  input wire CLK_SEL_ALT,
  input wire BOOT_MAP,
  input wire SWD_ENABLE
);
  // filter plus synchroniser and hold slack
  localparam int LAT = FILT + 6;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  slverr_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  pin_reset_a: assert property ($fell(RESET_PIN_N) ##1
    (!RESET_PIN_N && !DPD_ACTIVE)[*3] |-> ##[0:LAT]
    !CHIP_RESET_N) else $error("pin low gave no reset");
  rst_hold_a: assert property (!CHIP_RESET_N && !RESET_PIN_N
    |=> !CHIP_RESET_N) else $error("reset dropped with pin low");
  swd_reset_a: assert property (!CHIP_RESET_N &&
    !$past(CHIP_RESET_N) |-> !SWD_ENABLE) else $error("debug on in reset");
  dpd_power_a: assert property (DPD_ACTIVE && $past(DPD_ACTIVE)
    |-> !MAIN_POWER_EN && !IRC_ENABLE) else $error("power on in sleep");
  flash_init_a: assert property (!CHIP_RESET_N && !DPD_ACTIVE &&
    !$past(CHIP_RESET_N) && !$past(DPD_ACTIVE) |-> FLASH_INIT && IRC_ENABLE)
    else $error("reset without flash init");
  rc_clock_a: assert property (!CHIP_RESET_N |=> !CLK_SEL_ALT)
    else $error("alternate clock after reset");
  boot_map_a: assert property ($rose(CHIP_RESET_N) |-> BOOT_MAP)
    else $error("boot block not mapped");
  wake_a: assert property (DPD_ACTIVE &&
    (!WAKE_REQUEST_PIN_N || RTC_WAKE) |-> ##[1:10] !DPD_ACTIVE)
    else $error("no wake-up");
endmodule // rpc_top_chk
bind rpc_top rpc_top_chk #(.FILT(FILT)) u_rpc_top_chk (.CLOCK, .RST_N,
  .RESET_PIN_N, .WAKE_REQUEST_PIN_N, .RTC_WAKE, .PREADY, .PSLVERR,
  .CHIP_RESET_N, .IRC_ENABLE, .FLASH_INIT, .MAIN_POWER_EN, .DPD_ACTIVE,
  .CLK_SEL_ALT, .BOOT_MAP, .SWD_ENABLE);

// File: verification/rpc_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
module rpc_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic [5:0] e6;
  wire [31:0] prdata, prot_word;
  wire pready, pslverr, chip_reset_n, osc_en, flash_init, main_power_en;
  wire dpd_active, clk_sel_alt, boot_map, supply_irq, swd_en, scan_en;
  wire prog_en, prog_lock0, prog_erase_only, prog_pin_sample, app_prog_en;
  wire reset_pin_n, wake_pin_n, rtc_wake, wdt_reset, below_l0, below_l1;
  wire [5:0] prot_outs = {swd_en, prog_lock0, prog_erase_only, prog_en,
    app_prog_en, prog_pin_sample};
  int failures = 0, n_compared = 0, cyc = 0;

  // 200 MHz
  always #2.5 clk = ~clk;
  rpc_top u_rpc_top (.CLOCK(clk), .RST_N(rst_n), .RESET_PIN_N(reset_pin_n),
    .WAKE_REQUEST_PIN_N(wake_pin_n), .RTC_WAKE(rtc_wake),
    .WDT_RESET(wdt_reset), .BOD_BELOW_L0(below_l0), .BOD_BELOW_L1(below_l1),
    .PROT_WORD(prot_word), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CHIP_RESET_N(chip_reset_n), .IRC_ENABLE(osc_en),
    .FLASH_INIT(flash_init), .MAIN_POWER_EN(main_power_en),
    .DPD_ACTIVE(dpd_active), .CLK_SEL_ALT(clk_sel_alt), .BOOT_MAP(boot_map),
    .BOD_IRQ(supply_irq), .SWD_ENABLE(swd_en), .JTAG_BSCAN_ENABLE(scan_en),
    .ISP_ENABLE(prog_en), .ISP_SECTOR0_LOCK(prog_lock0),
    .ISP_ERASE_ONLY(prog_erase_only), .ISP_PIN_SAMPLE(prog_pin_sample),
    .IAP_ENABLE(app_prog_en));
  rpc_far_side u_rpc_far_side (.clk(clk), .dpd(dpd_active),
    .reset_pin_n(reset_pin_n), .wake_pin_n(wake_pin_n), .rtc_wake(rtc_wake),
    .wdt_reset(wdt_reset), .below_l0(below_l0), .below_l1(below_l1),
    .prot_word(prot_word));

  // setup cycle, then access held until the slave answers
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 40);
    if (pready !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no ready", $time);
      report_and_stop();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait on chip reset or on the sleep flag
  task automatic wait_for(input logic dpd, input logic v);
    int n;
    n = 0;
    while ((dpd ? dpd_active : chip_reset_n) !== v && ++n < 400)
      @(posedge clk);
    if (n >= 400) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_for(0, 1);
    apb(0, 8'h08, 0);
    `CHK(q, 32'h04)
    apb(0, 8'h00, 0);
    `CHK({q, boot_map, clk_sel_alt}, {32'h40, 2'b10})
    apb(0, 8'h10, 0);
    `CHK({err, q}, 33'h100000000)
    $display("test defaults done");
    // pin pulse of 55 ns, watchdog, brownout at level 0
    for (int s = 0; s < 3; s++) begin
      apb(1, 8'h08, 32'h3F);
      if (s == 2)
        apb(1, 8'h00, 32'h08);
      u_rpc_far_side.set_lines(s == 0 ? 6'h10 : s == 1 ? 6'h34 : 6'h32);
      repeat (10) @(posedge clk);
      u_rpc_far_side.set_lines(6'h30);
      wait_for(0, 0);
      @(posedge clk);
      `CHK({flash_init, osc_en}, 2'b11)
      wait_for(0, 1);
      apb(0, 8'h08, 0);
      `CHK(q[3:0], 4'b0001 << (s == 2 ? 3 : s))
      `CHK(boot_map, 1'b1)
    end
    $display("test sources done");
    // only the selected level reaches interrupt and status
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h00, 32'h40 | {30'h0, k[1], 1'b0});
      u_rpc_far_side.set_lines({4'hC, k[1] ? {~k[0], k[0]} : {k[0], ~k[0]}});
      repeat (4) @(posedge clk);
      apb(0, 8'h04, 0);
      `CHK({supply_irq, q[0]}, {2{k[0]}})
    end
    u_rpc_far_side.set_lines(6'h30);
    $display("test brownout done");
    // each protection level, latched under a held pin reset
    for (int l = 3; l >= 0; l--) begin
      u_rpc_far_side.set_prot(l);
      u_rpc_far_side.set_lines(6'h10);
      wait_for(0, 0);
      repeat (2) @(posedge clk);
      `CHK({scan_en, swd_en}, 2'b10)
      u_rpc_far_side.set_lines(6'h30);
      wait_for(0, 1);
      apb(0, 8'h0C, 0);
      `CHK(q, l)
      e6 = {l == 0, l == 1, l == 2, l != 3, 1'b1, l != 3};
      `CHK(prot_outs, e6)
    end
    apb(1, 8'h00, 32'h50);
    repeat (2) @(posedge clk);
    `CHK(prog_pin_sample, 1'b0)
    $display("test protection done");
    // locked entry is refused, then pin and timer wake-ups
    apb(1, 8'h08, 32'h3F);
    apb(1, 8'h00, 32'h41);
    apb(1, 8'h00, 32'h141);
    repeat (4) @(posedge clk);
    apb(0, 8'h08, 0);
    `CHK({dpd_active, q[5]}, 2'b01)
    for (int w = 0; w < 2; w++) begin
      apb(1, 8'h08, 32'h3F);
      apb(1, 8'h00, 32'h40);
      apb(1, 8'h00, 32'h160);
      repeat (20) @(posedge clk);
      `CHK({dpd_active, main_power_en, osc_en}, 3'b100)
      u_rpc_far_side.set_lines(w ? 6'h38 : 6'h20);
      wait_for(1, 0);
      wait_for(0, 0);
      u_rpc_far_side.set_lines(6'h30);
      wait_for(0, 1);
      apb(0, 8'h08, 0);
      `CHK({q[4], clk_sel_alt}, 2'b10)
    end
    $display("test sleep done");
    report_and_stop();
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      report_and_stop();
    end
  end
endmodule // rpc_top_tb_top
